// File: inc/osl_pkg.sv
// constants and carrier types for the output status signal logic
package osl_pkg;
    localparam int FREQ_W   = 16;
    localparam int TIME_W   = 20;
    localparam int FUNC_W   = 8;
    localparam int NUM_TERM = 5;
    localparam int NUM_OUT  = 6;
    localparam int RELAY_IX = 5;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;

    localparam logic [ADDR_W-1:0] ADDR_FUNC_LO   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_FUNC_HI   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_POLARITY  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_THRESH1   = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_THRESH2   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_TIME_WARN = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h18;

    localparam logic [FUNC_W-1:0] FUNC_RUN   = 8'h00;
    localparam logic [FUNC_W-1:0] FUNC_CSP   = 8'h01;
    localparam logic [FUNC_W-1:0] FUNC_OV1   = 8'h02;
    localparam logic [FUNC_W-1:0] FUNC_ALARM = 8'h05;
    localparam logic [FUNC_W-1:0] FUNC_RC1   = 8'h06;
    localparam logic [FUNC_W-1:0] FUNC_RTO   = 8'h0B;
    localparam logic [FUNC_W-1:0] FUNC_PTO   = 8'h0C;
    localparam logic [FUNC_W-1:0] FUNC_OV2   = 8'h18;
    localparam logic [FUNC_W-1:0] FUNC_RC2   = 8'h19;

    localparam logic [DATA_W-1:0] FUNC_LO_RST   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] FUNC_HI_RST   = 32'h0000_0500;
    localparam logic [DATA_W-1:0] POLARITY_RST  = 32'h0000_0020;
    localparam logic [DATA_W-1:0] THRESH_RST    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] TIME_WARN_RST = 32'h0000_0000;

    localparam int THR_DECEL_LSB = 16;
    localparam int TIME_VAL_W    = 14;
    localparam int TIME_EXT_BIT  = 16;
    localparam int STAT_TERM_LSB = 8;

    localparam int PCT_DIV       = 100;
    localparam int PCT_ON        = 1;
    localparam int PCT_OFF       = 2;
    localparam int TIME_UNIT_STD = 10;
    localparam int TIME_UNIT_EXT = 100;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [FREQ_W-1:0] out_freq;
        logic [FREQ_W-1:0] max_freq;
        logic [FREQ_W-1:0] frequency_command_setting;
        logic [FREQ_W-1:0] multispeed_setting;
        logic              multispeed_active;
        logic              running;
        logic              dc_braking;
        logic              tripped;
        logic              decelerating;
        logic [TIME_W-1:0] cumulative_run_time;
        logic [TIME_W-1:0] cumulative_power_time;
    } osl_drive_state_t;
endpackage : osl_pkg

// File: hdl/osl_output_status.sv
// output status signal logic with AXI4-Lite register slave
// Summary of operation
// (R1) polarity 00: output closes while signal asserted
// (R2) polarity 01: output opens while signal asserted
// (R3) each terminal and relay has own polarity
// (R4) relay paths complementary; trip closes first path
// (R5) run signal asserted while operating, incl. braking
// (R6) codes 01,02,06,24,25 select arrival variants
// (R7) arrival on at target-1%, off below -2%
// (R8) constant-speed target is active frequency command
// (R9) overreached asserts above accel/decel threshold pair
// (R10) reached-only asserts only near its threshold
// (R11) accelerating: on at -1%, off above +2%
// (R12) decelerating: on at +1%, off below -2%
// (R13) zero threshold disables its arrival output
// (R14) time-over outputs when cumulative time exceeds setting
// (R15) warning setting zero disables both time outputs
// (R16) standard warning setting counts tens of hours
// (R17) extended warning setting counts hundreds of hours
// (R18) comparisons every cycle, hysteresis flops reset cleared
// (R19) terminal drives selected signal xor polarity
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module osl_output_status
    import osl_pkg::*;
(
    input  wire logic               I_REF_CLK,
    input  wire logic               I_SYS_RST,
    input  wire osl_drive_state_t   I_DRIVE,
    input  wire logic [ADDR_W-1:0]  I_S_AXI_AWADDR,
    input  wire logic               I_S_AXI_AWVALID,
    output logic                    O_S_AXI_AWREADY,
    input  wire logic [DATA_W-1:0]  I_S_AXI_WDATA,
    input  wire logic [3:0]         I_S_AXI_WSTRB,
    input  wire logic               I_S_AXI_WVALID,
    output logic                    O_S_AXI_WREADY,
    output logic [1:0]              O_S_AXI_BRESP,
    output logic                    O_S_AXI_BVALID,
    input  wire logic               I_S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0]  I_S_AXI_ARADDR,
    input  wire logic               I_S_AXI_ARVALID,
    output logic                    O_S_AXI_ARREADY,
    output logic [DATA_W-1:0]       O_S_AXI_RDATA,
    output logic [1:0]              O_S_AXI_RRESP,
    output logic                    O_S_AXI_RVALID,
    input  wire logic               I_S_AXI_RREADY,
    output logic [NUM_TERM-1:0]     O_OUT_TERMINAL,
    output logic                    O_RELAY_PATH_FIRST,
    output logic                    O_RELAY_PATH_SECOND
);
    localparam int WF = FREQ_W + 2;

    logic [DATA_W-1:0] func_lo_q, func_hi_q, pol_q, thr1_q, thr2_q, time_q;
    logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [DATA_W-1:0] rdata_q, wdata_q;
    logic [3:0]        wstrb_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [NUM_TERM-1:0] term_q;
    logic              relay_first_q, relay_second_q;
    logic              csp_q, rto_q, pto_q;
    logic [1:0]        over_q, reach_q;
    logic [NUM_OUT-1:0] sig;
    logic [FUNC_W-1:0] func_sel [NUM_OUT];
    logic [WF-1:0]     f_w, p1_w, p2_w, tgt_w;
    logic [WF-1:0]     thr_w [2];
    logic [TIME_W-1:0] warn_limit;
    logic [TIME_VAL_W-1:0] warn_val;

    // byte-lane merge of a write into a register word
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [3:0]        strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // write address and data channels, taken in either order
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (awready_q && I_S_AXI_AWVALID) begin
                awready_q <= 1'b0;
                awaddr_q  <= I_S_AXI_AWADDR;
            end
            if (wready_q && I_S_AXI_WVALID) begin
                wready_q <= 1'b0;
                wdata_q  <= I_S_AXI_WDATA;
                wstrb_q  <= I_S_AXI_WSTRB;
            end
            if (!awready_q && !wready_q && !bvalid_q) begin
                bvalid_q <= 1'b1;
                if (awaddr_q <= ADDR_STATUS && awaddr_q[1:0] == 2'h0) begin
                    bresp_q <= RESP_OKAY;
                end else begin
                    bresp_q <= RESP_SLVERR;
                end
            end
            if (bvalid_q && I_S_AXI_BREADY) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // register file; status word is read-only and ignores writes
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            func_lo_q <= FUNC_LO_RST;
            func_hi_q <= FUNC_HI_RST;
            pol_q     <= POLARITY_RST;
            thr1_q    <= THRESH_RST;
            thr2_q    <= THRESH_RST;
            time_q    <= TIME_WARN_RST;
        end else if (!awready_q && !wready_q && !bvalid_q) begin
            if (awaddr_q == ADDR_FUNC_LO) begin
                func_lo_q <= merge(func_lo_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_FUNC_HI) begin
                func_hi_q <= merge(func_hi_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_POLARITY) begin
                pol_q <= merge(pol_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_THRESH1) begin
                thr1_q <= merge(thr1_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_THRESH2) begin
                thr2_q <= merge(thr2_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_TIME_WARN) begin
                time_q <= merge(time_q, wdata_q, wstrb_q);
            end
        end
    end

    // read channel; answer on the same edge that takes the address
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (arready_q && I_S_AXI_ARVALID) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= RESP_OKAY;
            if (I_S_AXI_ARADDR == ADDR_FUNC_LO) begin
                rdata_q <= func_lo_q;
            end else if (I_S_AXI_ARADDR == ADDR_FUNC_HI) begin
                rdata_q <= {16'h0000, func_hi_q[15:0]};
            end else if (I_S_AXI_ARADDR == ADDR_POLARITY) begin
                rdata_q <= {26'h0, pol_q[NUM_OUT-1:0]};
            end else if (I_S_AXI_ARADDR == ADDR_THRESH1) begin
                rdata_q <= thr1_q;
            end else if (I_S_AXI_ARADDR == ADDR_THRESH2) begin
                rdata_q <= thr2_q;
            end else if (I_S_AXI_ARADDR == ADDR_TIME_WARN) begin
                rdata_q <= {15'h0, time_q[TIME_EXT_BIT], 2'h0, time_q[TIME_VAL_W-1:0]};
            end else if (I_S_AXI_ARADDR == ADDR_STATUS) begin
                rdata_q <= {18'h0, relay_first_q, term_q,
                             reach_q, over_q, csp_q, pto_q, rto_q, sig[RELAY_IX]};
            end else begin
                rdata_q <= '0;
                rresp_q <= RESP_SLVERR;
            end
        end else if (rvalid_q && I_S_AXI_RREADY) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // wide copies so sums and differences never wrap
    always_comb begin
        f_w   = WF'(I_DRIVE.out_freq);
        p1_w  = WF'((32'(I_DRIVE.max_freq) * PCT_ON) / PCT_DIV);
        p2_w  = WF'((32'(I_DRIVE.max_freq) * PCT_OFF) / PCT_DIV);
        // (R8) active command target
        tgt_w = I_DRIVE.multispeed_active ? WF'(I_DRIVE.multispeed_setting)
                                          : WF'(I_DRIVE.frequency_command_setting);
    end

    // (R7) constant-speed hysteresis flop
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            csp_q <= 1'b0;
        end else if (f_w + p1_w >= tgt_w) begin
            csp_q <= 1'b1;
        end else if (f_w + p2_w < tgt_w) begin
            csp_q <= 1'b0;
        end
    end

    // one comparator pair per threshold set; g selects first or second
    for (genvar g = 0; g < 2; g++) begin : g_thr
        logic [DATA_W-1:0] pair;
        assign pair = (g == 0) ? thr1_q : thr2_q;
        // (R9) accel or decel threshold by ramp direction
        assign thr_w[g] = I_DRIVE.decelerating ? WF'(pair[THR_DECEL_LSB +: FREQ_W])
                                               : WF'(pair[FREQ_W-1:0]);

        // (R18) hysteresis held per output, reset cleared
        always_ff @(posedge I_REF_CLK) begin
            if (I_SYS_RST) begin
                over_q[g] <= 1'b0;
            // (R13) zero threshold disables
            end else if (thr_w[g] == '0) begin
                over_q[g] <= 1'b0;
            // (R7) on at minus one percent
            end else if (f_w + p1_w >= thr_w[g]) begin
                over_q[g] <= 1'b1;
            end else if (f_w + p2_w < thr_w[g]) begin
                over_q[g] <= 1'b0;
            end
        end

        always_ff @(posedge I_REF_CLK) begin
            if (I_SYS_RST) begin
                reach_q[g] <= 1'b0;
            // (R13) zero threshold disables
            end else if (thr_w[g] == '0) begin
                reach_q[g] <= 1'b0;
            // (R10) leave once well beyond
            end else if (f_w > thr_w[g] + p2_w || f_w + p2_w < thr_w[g]) begin
                reach_q[g] <= 1'b0;
            // (R12) decel entry at plus one percent
            end else if (I_DRIVE.decelerating && f_w <= thr_w[g] + p1_w) begin
                reach_q[g] <= 1'b1;
            // (R11) accel entry at minus one percent
            end else if (!I_DRIVE.decelerating && f_w + p1_w >= thr_w[g]) begin
                reach_q[g] <= 1'b1;
            end
        end
    end

    // (R16) tens of hours, (R17) hundreds in extended range
    assign warn_val   = time_q[TIME_VAL_W-1:0];
    assign warn_limit = time_q[TIME_EXT_BIT]
                      ? TIME_W'(32'(warn_val) * TIME_UNIT_EXT)
                      : TIME_W'(32'(warn_val) * TIME_UNIT_STD);

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            rto_q <= 1'b0;
            pto_q <= 1'b0;
        // (R15) zero setting disables both
        end else if (warn_val == '0) begin
            rto_q <= 1'b0;
            pto_q <= 1'b0;
        end else begin
            // (R14) exceed compares
            rto_q <= I_DRIVE.cumulative_run_time > warn_limit;
            pto_q <= I_DRIVE.cumulative_power_time > warn_limit;
        end
    end

    // per-output function select and polarity
    for (genvar t = 0; t < NUM_OUT; t++) begin : g_out
        assign func_sel[t] = (t < 4) ? func_lo_q[(t%4)*FUNC_W +: FUNC_W]
                                     : func_hi_q[(t%4)*FUNC_W +: FUNC_W];
        always_comb begin
            // (R6) function code decode
            case (func_sel[t])
                // (R5) braking counts as running
                FUNC_RUN:   sig[t] = I_DRIVE.running | I_DRIVE.dc_braking;
                FUNC_CSP:   sig[t] = csp_q;
                FUNC_OV1:   sig[t] = over_q[0];
                FUNC_RC1:   sig[t] = reach_q[0];
                FUNC_OV2:   sig[t] = over_q[1];
                FUNC_RC2:   sig[t] = reach_q[1];
                FUNC_ALARM: sig[t] = I_DRIVE.tripped;
                FUNC_RTO:   sig[t] = rto_q;
                FUNC_PTO:   sig[t] = pto_q;
                default:    sig[t] = 1'b0;
            endcase
        end
        if (t < NUM_TERM) begin : g_term
            always_ff @(posedge I_REF_CLK) begin
                if (I_SYS_RST) begin
                    term_q[t] <= 1'b0;
                end else begin
                    // (R1) (R2) (R3) (R19) per-terminal xor
                    term_q[t] <= sig[t] ^ pol_q[t];
                end
            end
        end
    end

    // relay at reset sits as if powered down: first open, second closed
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            relay_first_q  <= 1'b0;
            relay_second_q <= 1'b1;
        end else begin
            // (R4) complementary relay paths
            relay_first_q  <= sig[RELAY_IX] ^ pol_q[RELAY_IX];
            relay_second_q <= ~(sig[RELAY_IX] ^ pol_q[RELAY_IX]);
        end
    end

    assign O_S_AXI_AWREADY     = awready_q;
    assign O_S_AXI_WREADY      = wready_q;
    assign O_S_AXI_BVALID      = bvalid_q;
    assign O_S_AXI_BRESP       = bresp_q;
    assign O_S_AXI_ARREADY     = arready_q;
    assign O_S_AXI_RVALID      = rvalid_q;
    assign O_S_AXI_RDATA       = rdata_q;
    assign O_S_AXI_RRESP       = rresp_q;
    assign O_OUT_TERMINAL      = term_q;
    assign O_RELAY_PATH_FIRST  = relay_first_q;
    assign O_RELAY_PATH_SECOND = relay_second_q;
endmodule : osl_output_status

// File: verif/osl_load_panel.sv
// lamp panel wired to the output terminals
`timescale 1ns/1ps
module osl_load_panel
    import osl_pkg::*;
(
    input  wire logic [NUM_TERM-1:0] i_term,
    input  wire logic                i_first,
    input  wire logic                i_second,
    output logic [NUM_TERM-1:0]      o_lamp,
    output logic                     o_alarm_lamp
);
    // lamp lit while its terminal conducts
    assign o_lamp = i_term;
    // both paths closed would be a wiring fault, so lamp stays dark then
    assign o_alarm_lamp = i_first & ~i_second;
endmodule : osl_load_panel

// File: verif/osl_output_status_checker.sv
// assertions on the status outputs and register bus
`timescale 1ns/1ps
module osl_output_status_checker
    import osl_pkg::*;
(
    input wire logic              I_REF_CLK,
    input wire logic              I_SYS_RST,
    input wire osl_drive_state_t  I_DRIVE,
    input wire logic [ADDR_W-1:0] I_S_AXI_AWADDR,
    input wire logic              I_S_AXI_AWVALID,
    input wire logic              O_S_AXI_AWREADY,
    input wire logic [DATA_W-1:0] I_S_AXI_WDATA,
    input wire logic              I_S_AXI_WVALID,
    input wire logic              O_S_AXI_WREADY,
    input wire logic [1:0]        O_S_AXI_BRESP,
    input wire logic              O_S_AXI_BVALID,
    input wire logic              I_S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] I_S_AXI_ARADDR,
    input wire logic              I_S_AXI_ARVALID,
    input wire logic              O_S_AXI_ARREADY,
    input wire logic [DATA_W-1:0] O_S_AXI_RDATA,
    input wire logic [1:0]        O_S_AXI_RRESP,
    input wire logic              O_S_AXI_RVALID,
    input wire logic [NUM_TERM-1:0] O_OUT_TERMINAL,
    input wire logic              O_RELAY_PATH_FIRST,
    input wire logic              O_RELAY_PATH_SECOND
);
    logic [ADDR_W-1:0] aw_q;
    logic [DATA_W-1:0] w_q;
    logic [5:0]        pol_q;
    logic [7:0]        t0f_q;
    logic [7:0]        rlf_q;
    logic [1:0]        quiet_q;
    always_ff @(posedge I_REF_CLK) begin
        if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) aw_q <= I_S_AXI_AWADDR;
        if (I_S_AXI_WVALID && O_S_AXI_WREADY) w_q <= I_S_AXI_WDATA;
    end
    // full-word writes only; quiet_q hides the settling edges
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            pol_q <= POLARITY_RST[5:0];
            t0f_q <= FUNC_LO_RST[7:0];
            rlf_q <= FUNC_HI_RST[15:8];
            quiet_q <= 2'h0;
        end else if (O_S_AXI_BVALID) begin
            quiet_q <= 2'h0;
            if (aw_q == ADDR_POLARITY) pol_q <= w_q[5:0];
            if (aw_q == ADDR_FUNC_LO) t0f_q <= w_q[7:0];
            if (aw_q == ADDR_FUNC_HI) rlf_q <= w_q[15:8];
        end else if (quiet_q != 2'h3) begin
            quiet_q <= quiet_q + 2'h1;
        end
    end
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_relay_compl: assert property (O_RELAY_PATH_SECOND == !O_RELAY_PATH_FIRST)
        else $error("relay paths not complementary");
    a_reset_clear: assert property (disable iff (1'b0) I_SYS_RST |=>
        O_OUT_TERMINAL == '0 && !O_RELAY_PATH_FIRST) else $error("outputs not cleared");
    a_relay_trip: assert property (quiet_q == 2'h3 && rlf_q == FUNC_ALARM |->
        O_RELAY_PATH_FIRST == ($past(I_DRIVE.tripped) ^ pol_q[5]))
        else $error("relay path does not follow trip");
    a_run_term: assert property (quiet_q == 2'h3 && t0f_q == FUNC_RUN |->
        O_OUT_TERMINAL[0] == (($past(I_DRIVE.running) | $past(I_DRIVE.dc_braking))
        ^ pol_q[0])) else $error("terminal 0 does not follow run");
    a_aw_block: assert property (O_S_AXI_BVALID |-> !O_S_AXI_AWREADY && !O_S_AXI_WREADY)
        else $error("write accepted during response");
    a_b_hold: assert property (O_S_AXI_BVALID && !I_S_AXI_BREADY |=>
        O_S_AXI_BVALID && $stable(O_S_AXI_BRESP)) else $error("write response dropped");
    a_r_answer: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY |=>
        O_S_AXI_RVALID && !O_S_AXI_ARREADY) else $error("read not answered");
    a_bad_read: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY &&
        I_S_AXI_ARADDR > ADDR_STATUS |=> O_S_AXI_RRESP == RESP_SLVERR && O_S_AXI_RDATA == '0)
        else $error("unmapped read not refused");
    c_trip: cover property (quiet_q == 2'h3 && !O_RELAY_PATH_FIRST);
    c_slverr: cover property (O_S_AXI_BVALID && O_S_AXI_BRESP == RESP_SLVERR);
    c_all_on: cover property (O_OUT_TERMINAL == 5'h1F);
endmodule : osl_output_status_checker

bind osl_output_status osl_output_status_checker u_chk (.*);

// File: verif/tb_osl_output_status.sv
// self-checking bench for the output status logic
`timescale 1ns/1ps
module tb_osl_output_status import osl_pkg::*;;
    logic                clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic                awready, wready, bvalid, arready, rvalid, first, second, alarm_lamp;
    logic [7:0]          awaddr, araddr;
    logic [31:0]         wdata, rdata, flo, fhi, pol, th1, th2, tw;
    logic [1:0]          bresp, rresp;
    logic [NUM_TERM-1:0] term, lamp;
    osl_drive_state_t    drv;
    int                  n_mismatch, cmp_count, csp, ov1, ov2, rc1, rc2;
    osl_output_status uut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_DRIVE(drv),
        .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awvalid), .O_S_AXI_AWREADY(awready),
        .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(4'hF), .I_S_AXI_WVALID(wvalid),
        .O_S_AXI_WREADY(wready), .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid),
        .I_S_AXI_BREADY(bready), .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arvalid),
        .O_S_AXI_ARREADY(arready), .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp),
        .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready), .O_OUT_TERMINAL(term),
        .O_RELAY_PATH_FIRST(first), .O_RELAY_PATH_SECOND(second));
    osl_load_panel u_panel (.i_term(term), .i_first(first), .i_second(second),
        .o_lamp(lamp), .o_alarm_lamp(alarm_lamp));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while ((awvalid || wvalid) && n < 64);
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!bvalid && n < 128);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 64);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] r;
        axi_wr(a, v, r);
        chk("bresp", RESP_OKAY, r);
    endtask : wreg
    function automatic int hys(int s, int f, int on, int off);
        if (f >= on) return 1;
        if (f < off) return 0;
        return s;
    endfunction : hys
    function automatic int rch(int s, int f, int t, logic dec, int p1, int p2);
        if (t == 0 || f > t + p2 || f < t - p2) return 0;
        if (dec ? f <= t + p1 : f >= t - p1) return 1;
        return s;
    endfunction : rch
    function automatic logic sel(logic [7:0] c);
        int lim = tw[13:0] * (tw[16] ? 100 : 10);
        case (c)
            FUNC_RUN: return drv.running | drv.dc_braking;
            FUNC_CSP: return csp[0];
            FUNC_OV1: return ov1[0];
            FUNC_ALARM: return drv.tripped;
            FUNC_RC1: return rc1[0];
            FUNC_RTO: return tw[13:0] != 0 && drv.cumulative_run_time > lim;
            FUNC_PTO: return tw[13:0] != 0 && drv.cumulative_power_time > lim;
            FUNC_OV2: return ov2[0];
            FUNC_RC2: return rc2[0];
            default: return 1'b0;
        endcase
    endfunction : sel
    task automatic apply(input osl_drive_state_t d);
        int f, p1, p2, t;
        logic [NUM_TERM-1:0] e;
        logic er;
        @(posedge clk);
        drv <= d;
        f = d.out_freq;
        p1 = d.max_freq * PCT_ON / PCT_DIV;
        p2 = d.max_freq * PCT_OFF / PCT_DIV;
        t = d.multispeed_active ? d.multispeed_setting : d.frequency_command_setting;
        csp = hys(csp, f, t - p1, t - p2);
        t = d.decelerating ? th1[31:16] : th1[15:0];
        ov1 = t == 0 ? 0 : hys(ov1, f, t - p1, t - p2);
        rc1 = rch(rc1, f, t, d.decelerating, p1, p2);
        t = d.decelerating ? th2[31:16] : th2[15:0];
        ov2 = t == 0 ? 0 : hys(ov2, f, t - p1, t - p2);
        rc2 = rch(rc2, f, t, d.decelerating, p1, p2);
        repeat (3) @(posedge clk);
        for (int i = 0; i < NUM_TERM; i++) e[i] = sel(i < 4 ? flo[8*i+:8] : fhi[7:0]) ^ pol[i];
        er = sel(fhi[15:8]) ^ pol[5];
        chk("terminals", e, lamp);
        chk("relay", {er, ~er, er}, {alarm_lamp, second, first});
    endtask : apply
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        osl_drive_state_t d;
        logic [1:0] r;
        logic [31:0] v;
        static logic [7:0] ad [7] = '{ADDR_FUNC_LO, ADDR_FUNC_HI, ADDR_POLARITY, ADDR_THRESH1,
            ADDR_THRESH2, ADDR_TIME_WARN, 8'h1C};
        static logic [31:0] ex [7] = '{FUNC_LO_RST, FUNC_HI_RST, POLARITY_RST, THRESH_RST,
            THRESH_RST, TIME_WARN_RST, 32'h0};
        {rst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        rst = 1'b1;
        drv = '0;
        {flo, fhi, pol, th1, th2, tw} = {FUNC_LO_RST, FUNC_HI_RST, POLARITY_RST, 96'h0};
        v = $urandom(47);
        d = '0;
        d.max_freq = 16'd12000;
        d.frequency_command_setting = 16'd6000;
        d.multispeed_setting = 16'd4000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            axi_rd(ad[i], v, r);
            chk("rdata", ex[i], v);
            chk("rresp", i == 6 ? RESP_SLVERR : RESP_OKAY, r);
        end
        axi_wr(8'h09, 32'hFFFF_FFFF, r);
        chk("bresp", RESP_SLVERR, r);
        for (int k = 0; k < 4; k++) begin
            pol = $urandom & 32'h3F;
            wreg(ADDR_POLARITY, pol);
            axi_rd(ADDR_POLARITY, v, r);
            chk("polarity", pol, v);
            for (int i = 0; i < 8; i++) begin
                {d.tripped, d.dc_braking, d.running} = 3'(i);
                apply(d);
            end
        end
        {flo, fhi, th1, th2} = {FUNC_OV2, FUNC_RC1, FUNC_OV1, FUNC_CSP, 16'h0, FUNC_ALARM,
            FUNC_RC2, 16'd3000, 16'd5000, 16'd0, 16'd7000};
        foreach (ad[i]) if (i < 5) wreg(ad[i], i == 0 ? flo : i == 1 ? fhi : i == 2 ? pol :
            i == 3 ? th1 : th2);
        for (int s = 0; s < 500; s++) begin
            d.decelerating = s < 300 ? s >= 150 : 1'($urandom);
            d.out_freq = s < 150 ? 16'(s * 60) : s < 300 ? 16'((299 - s) * 60) :
                16'($urandom_range(9000, 0));
            d.multispeed_active = s < 300 ? s[6] : 1'($urandom);
            apply(d);
        end
        flo = {16'h0, FUNC_PTO, FUNC_RTO};
        wreg(ADDR_FUNC_LO, flo);
        for (int k = 0; k < 44; k++) begin
            tw = k == 0 ? 32'h0 : k == 1 ? 32'd100 : k == 2 ? 32'h1_03E8 : k == 3 ? 32'd9999 :
                {15'h0, 1'($urandom), 2'h0, 14'($urandom_range(6553, 0))};
            d.cumulative_run_time = k == 1 ? 20'd1001 : k == 2 ? 20'd100001 :
                k == 3 ? 20'd99990 : 20'($urandom);
            d.cumulative_power_time = k == 1 ? 20'd1000 : k == 2 ? 20'd100000 :
                k == 3 ? 20'd99991 : 20'($urandom);
            wreg(ADDR_TIME_WARN, tw);
            apply(d);
        end
        test_done();
    end
endmodule : tb_osl_output_status
